// [swm_master.sv]
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ns
`include "swm_consts.svh"
module swm_master #(
    parameter int RSTL_CYC = (`SWM_T_RSTL_NS + `SWM_CLK_NS - 1) / `SWM_CLK_NS,
    parameter int RSTH_CYC = (`SWM_T_RSTH_NS + `SWM_CLK_NS - 1) / `SWM_CLK_NS,
    parameter int PRES_CYC = (`SWM_T_PRES_NS + `SWM_CLK_NS - 1) / `SWM_CLK_NS,
    parameter int SLOT_CYC = (`SWM_T_SLOT_NS + `SWM_CLK_NS - 1) / `SWM_CLK_NS,
    parameter int LOW0_CYC = (`SWM_T_LOW0_NS + `SWM_CLK_NS - 1) / `SWM_CLK_NS
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        dq_i,
    output logic             dq_o,
    output logic             dq_oe
);
    localparam logic [16:0] RSTL  = 17'(RSTL_CYC);
    localparam logic [16:0] RSTH  = 17'(RSTH_CYC);
    localparam logic [16:0] PRES  = 17'(PRES_CYC);
    localparam logic [16:0] SLOT  = 17'(SLOT_CYC);
    localparam logic [16:0] LOW0  = 17'(LOW0_CYC);
    // Least low time rounds up, read sample point rounds down to stay before data valid ends
    localparam logic [16:0] LOW1  = 17'((`SWM_T_LOW1_NS + `SWM_CLK_NS - 1) / `SWM_CLK_NS);
    localparam logic [16:0] RDS   = 17'(`SWM_T_RDS_NS / `SWM_CLK_NS);

    logic                     sync1_r, sync2_r;
    swm_pkg::swm_state_e      st_r, st_nxt;
    swm_pkg::swm_phase_e      ph_r, ph_nxt;
    logic [16:0]              cnt_r, cnt_nxt;
    logic [7:0]               sh_r, sh_nxt;
    logic [2:0]               bit_r, bit_nxt;
    logic [1:0]               op_r, op_nxt;
    logic                     pres_r, pres_nxt;
    logic                     serr_r, serr_nxt;
    logic                     cwait_r, cwait_nxt;
    logic                     cdone_r, cdone_nxt;
    logic [3:0]               romleft_r, romleft_nxt;
    logic [1:0]               auth_r, auth_nxt;
    logic [7:0]               rx_r, rx_nxt;
    logic [15:0]              cmd_r, cmd_nxt;
    logic                     oe_r, oe_nxt;
    logic [31:0]              prdata_nxt;
    logic                     pready_nxt, pslverr_nxt;
    logic                     bus_done, hit_cmd, hit_stat, start;
    logic                     line_bit, wbit, last_bit, is_read;
    swm_pkg::swm_status_s     stat;

    // Line passes two flops before use; only the second is read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= 1'b1;
            sync2_r <= 1'b1;
        end else begin
            sync1_r <= dq_i;
            sync2_r <= sync1_r;
        end
    end
    assign line_bit = sync2_r;

    // APB: one wait state so read data leaves a flop
    assign bus_done = psel && penable && pready;
    assign hit_cmd  = (paddr == `SWM_ADDR_CMD);
    assign hit_stat = (paddr == `SWM_ADDR_STATUS);
    // Orders arriving while busy are dropped; software polls busy first
    assign start    = bus_done && pwrite && hit_cmd && (st_r == swm_pkg::ST_IDLE);

    always_comb begin
        stat           = '0;
        stat.rx        = rx_r;
        stat.phase     = ph_r;
        stat.copy_done = cdone_r;
        stat.copy_wait = cwait_r;
        stat.seq_err   = serr_r;
        stat.presence  = pres_r;
        stat.busy      = (st_r != swm_pkg::ST_IDLE);
        pready_nxt     = psel && penable && !pready;
        prdata_nxt     = prdata;
        pslverr_nxt    = 1'b0;
        if (pready_nxt) begin
            pslverr_nxt = !(hit_cmd || hit_stat);
            if (hit_cmd)
                prdata_nxt = {16'h0000, cmd_r};
            else if (hit_stat)
                // Bit 7 spare so the received byte sits in the upper byte of the half word
                prdata_nxt = {16'h0000, stat.rx, 1'b0, stat.phase, stat.copy_done, stat.copy_wait,
                              stat.seq_err, stat.presence, stat.busy};
            else
                prdata_nxt = 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata  <= prdata_nxt;
            pready  <= pready_nxt;
            pslverr <= pslverr_nxt;
        end
    end

    assign wbit     = sh_r[0];
    assign is_read  = (op_r == `SWM_OP_RBYTE) || (op_r == `SWM_OP_RBIT);
    assign last_bit = (op_r == `SWM_OP_RBIT) || (bit_r == 3'h7);

    function automatic logic rbyte_zero(input logic [1:0] op, input logic [7:0] sh);
        rbyte_zero = (op == `SWM_OP_RBIT) ? !sh[7] : (sh == 8'h00);
    endfunction

    always_comb begin
        st_nxt      = st_r;
        ph_nxt      = ph_r;
        cnt_nxt     = cnt_r;
        sh_nxt      = sh_r;
        bit_nxt     = bit_r;
        op_nxt      = op_r;
        pres_nxt    = pres_r;
        serr_nxt    = serr_r;
        cwait_nxt   = cwait_r;
        cdone_nxt   = cdone_r;
        romleft_nxt = romleft_r;
        auth_nxt    = auth_r;
        rx_nxt      = rx_r;
        cmd_nxt     = cmd_r;
        oe_nxt      = 1'b0;
        unique case (st_r)
            swm_pkg::ST_IDLE: begin
                // Line released while idle so a paused transaction never reads as reset
                oe_nxt = 1'b0;
                if (start) begin
                    cmd_nxt = pwdata[15:0];
                    op_nxt  = pwdata[`SWM_CMD_OP_LSB +: 2];
                    sh_nxt  = pwdata[`SWM_CMD_DATA_LSB +: 8];
                    bit_nxt = 3'h0;
                    cnt_nxt = 17'h00000;
                    oe_nxt  = 1'b1;
                    if (pwdata[`SWM_CMD_OP_LSB +: 2] == `SWM_OP_RESET) begin
                        // Reset always allowed: a failed authorization leaves no zero to wait for
                        st_nxt   = swm_pkg::ST_RST_LOW;
                        pres_nxt = 1'b0;
                        serr_nxt = 1'b0;
                    end else begin
                        st_nxt = swm_pkg::ST_SLOT_LOW;
                        if (ph_r == swm_pkg::PH_NONE)
                            serr_nxt = 1'b1;
                    end
                end
            end
            swm_pkg::ST_RST_LOW: begin
                oe_nxt  = 1'b1;
                cnt_nxt = cnt_r + 17'h00001;
                if (cnt_r == RSTL - 17'h00001) begin
                    oe_nxt  = 1'b0;
                    cnt_nxt = 17'h00000;
                    st_nxt  = swm_pkg::ST_RST_HIGH;
                end
            end
            swm_pkg::ST_RST_HIGH: begin
                cnt_nxt = cnt_r + 17'h00001;
                // Sample lands where every legal presence pulse is still low
                if (cnt_r == PRES)
                    pres_nxt = !line_bit;
                if (cnt_r == RSTH - 17'h00001) begin
                    st_nxt    = swm_pkg::ST_IDLE;
                    ph_nxt    = pres_r ? swm_pkg::PH_ROM : swm_pkg::PH_NONE;
                    romleft_nxt = 4'h0;
                    auth_nxt  = 2'h0;
                    cwait_nxt = 1'b0;
                    cdone_nxt = 1'b0;
                end
            end
            swm_pkg::ST_SLOT_LOW: begin
                oe_nxt  = 1'b1;
                cnt_nxt = cnt_r + 17'h00001;
                if ((is_read || wbit) ? (cnt_r == LOW1 - 17'h00001) : (cnt_r == LOW0 - 17'h00001)) begin
                    oe_nxt = 1'b0;
                    st_nxt = swm_pkg::ST_SLOT_REST;
                end
            end
            swm_pkg::ST_SLOT_REST: begin
                cnt_nxt = cnt_r + 17'h00001;
                if (is_read && cnt_r == RDS)
                    sh_nxt = {line_bit, sh_r[7:1]};
                // Slot plus recovery keeps the rate under the bus limit
                if (cnt_r == SLOT - 17'h00001) begin
                    cnt_nxt = 17'h00000;
                    bit_nxt = bit_r + 3'h1;
                    // Write shift at slot end; a zero bit is still held low at the read point
                    if (!is_read)
                        sh_nxt = {1'b0, sh_r[7:1]};
                    if (!last_bit) begin
                        oe_nxt = 1'b1;
                        st_nxt = swm_pkg::ST_SLOT_LOW;
                    end else begin
                        st_nxt = swm_pkg::ST_IDLE;
                        if (is_read)
                            rx_nxt = (op_r == `SWM_OP_RBIT) ? {7'h00, sh_r[7]} : sh_r;
                        if (romleft_r != 4'h0) begin
                            romleft_nxt = romleft_r - 4'h1;
                            if (romleft_r == 4'h1)
                                ph_nxt = swm_pkg::PH_MEM;
                        end else if (!is_read && ph_r == swm_pkg::PH_ROM) begin
                            if (cmd_r[15:8] == `SWM_ROM_READ || cmd_r[15:8] == `SWM_ROM_MATCH)
                                romleft_nxt = `SWM_ROM_BYTES;
                            else
                                ph_nxt = swm_pkg::PH_MEM;
                        end else if (!is_read && ph_r == swm_pkg::PH_MEM) begin
                            ph_nxt = swm_pkg::PH_DATA;
                            if (cmd_r[15:8] == `SWM_MEM_COPY)
                                auth_nxt = `SWM_AUTH_BYTES;
                        end else if (!is_read && auth_r != 2'h0) begin
                            auth_nxt = auth_r - 2'h1;
                            if (auth_r == 2'h1)
                                cwait_nxt = 1'b1;
                        end else if (is_read && cwait_r && rbyte_zero(op_r, sh_r)) begin
                            cwait_nxt = 1'b0;
                            cdone_nxt = 1'b1;
                        end
                    end
                end
            end
            default: begin
                st_nxt = swm_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r      <= swm_pkg::ST_IDLE;
            ph_r      <= swm_pkg::PH_NONE;
            cnt_r     <= 17'h00000;
            sh_r      <= 8'h00;
            bit_r     <= 3'h0;
            op_r      <= 2'h0;
            pres_r    <= 1'b0;
            serr_r    <= 1'b0;
            cwait_r   <= 1'b0;
            cdone_r   <= 1'b0;
            romleft_r <= 4'h0;
            auth_r    <= 2'h0;
            rx_r      <= 8'h00;
            cmd_r     <= 16'h0000;
            oe_r      <= 1'b0;
        end else begin
            st_r      <= st_nxt;
            ph_r      <= ph_nxt;
            cnt_r     <= cnt_nxt;
            sh_r      <= sh_nxt;
            bit_r     <= bit_nxt;
            op_r      <= op_nxt;
            pres_r    <= pres_nxt;
            serr_r    <= serr_nxt;
            cwait_r   <= cwait_nxt;
            cdone_r   <= cdone_nxt;
            romleft_r <= romleft_nxt;
            auth_r    <= auth_nxt;
            rx_r      <= rx_nxt;
            cmd_r     <= cmd_nxt;
            oe_r      <= oe_nxt;
        end
    end

    // Open drain: only ever pulls low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            dq_o <= 1'b0;
        else
            dq_o <= 1'b0;
    end
    assign dq_oe = oe_r;

endmodule // swm_master

// [swm_consts.svh]
`ifndef SWM_CONSTS_SVH
`define SWM_CONSTS_SVH

`define SWM_CLK_NS          10
`define SWM_T_RSTL_NS       480000
`define SWM_T_RSTH_NS       480000
`define SWM_T_PRES_NS       70000
`define SWM_T_SLOT_NS       65000
`define SWM_T_LOW0_NS       60000
`define SWM_T_LOW1_NS       2000
`define SWM_T_RDS_NS        13000

`define SWM_ADDR_CMD        12'h000
`define SWM_ADDR_STATUS     12'h004

`define SWM_OP_RESET        2'h0
`define SWM_OP_WBYTE        2'h1
`define SWM_OP_RBYTE        2'h2
`define SWM_OP_RBIT         2'h3
`define SWM_CMD_OP_LSB      0
`define SWM_CMD_DATA_LSB    8

`define SWM_ROM_READ        8'h33
`define SWM_ROM_MATCH       8'h55
`define SWM_ROM_SKIP        8'hcc
`define SWM_MEM_COPY        8'h55
`define SWM_MEM_READ        8'hf0
`define SWM_ROM_BYTES       4'h8
`define SWM_AUTH_BYTES      2'h3
`endif

// [swm_pkg.sv]
package swm_pkg;
    typedef enum logic [2:0] {
        ST_IDLE, ST_RST_LOW, ST_RST_HIGH, ST_SLOT_LOW, ST_SLOT_REST
    } swm_state_e;

    typedef enum logic [1:0] {
        PH_NONE, PH_ROM, PH_MEM, PH_DATA
    } swm_phase_e;

    typedef struct packed {
        logic [7:0] rx;
        logic [1:0] phase;
        logic       copy_done;
        logic       copy_wait;
        logic       seq_err;
        logic       presence;
        logic       busy;
    } swm_status_s;
endpackage

// [swm_master_props.sv]
`timescale 1ns/1ns
module swm_master_props #(
    parameter int RSTL_CYC = 48000,
    parameter int LOW0_CYC = 6000
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        dq_o,
    input wire logic        dq_oe
);
    int   hi_cnt_r;
    int   hi_cnt_nxt;
    logic mapped;
    assign mapped = (paddr == 12'h000) || (paddr == 12'h004);
    // Counts how long the master has held the line low (dq_oe); a device pull is not counted
    always_comb hi_cnt_nxt = dq_oe ? hi_cnt_r + 1 : 0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) hi_cnt_r <= 0;
        else hi_cnt_r <= hi_cnt_nxt;
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_one_wait: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
        else $error("pready not in second access cycle");
    a_ready_pulse: assert property (pready |=> !pready) else $error("pready held too long");
    a_ready_in_access: assert property (pready |-> psel && penable && $past(penable))
        else $error("pready outside access phase");
    a_err_unmapped: assert property (pready && !mapped |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_err_mapped: assert property (pready && mapped |-> !pslverr) else $error("mapped access refused");
    a_pin_low_only: assert property (dq_o == 1'b0) else $error("line driven high");
    a_low_width: assert property ($fell(dq_oe) |-> hi_cnt_r == 200 || hi_cnt_r == LOW0_CYC ||
        hi_cnt_r == RSTL_CYC) else $error("line low time wrong");
    a_reset_bound: assert property (hi_cnt_r <= RSTL_CYC) else $error("line held low too long");
    a_release_high: assert property ($fell(dq_oe) |-> !dq_oe [*8]) else $error("no recovery");
endmodule // swm_master_props
bind swm_master swm_master_props #(.RSTL_CYC(RSTL_CYC), .LOW0_CYC(LOW0_CYC)) u_swm_master_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .dq_o(dq_o), .dq_oe(dq_oe));

// [swm_dev_model.sv]
`timescale 1ns/1ns
module swm_dev_model #(
    parameter int COPY_NS   = 3000,
    parameter int MEM_BYTES = 128
) (
    input  wire logic line,
    output logic      pull_low
);
    logic [7:0] sh_r, ta_lo_r, ta_hi_r, es_r;
    logic       b;
    int         st, nb, ai;
    logic [7:0] pad [32];
    logic [7:0] mem [256];
    initial begin
        pull_low = 1'b0;
        ta_lo_r  = 8'h26;
        ta_hi_r  = 8'h00;
        es_r     = 8'h07;
        st       = 0;
        nb       = 0;
        ai       = 0;
        foreach (pad[i]) pad[i] = 8'(i);
        foreach (mem[i]) mem[i] = 8'h00;
    end
    task automatic rst_seq();
        @(posedge line);
        #500 pull_low = 1'b1;
        #2000 pull_low = 1'b0;
        st = 1;
        nb = 0;
    endtask
    task automatic take_byte();
        case (st)
            1: st = (sh_r == 8'hcc) ? 2 : 0;
            2: begin
                st = (sh_r == 8'h55) ? 3 : (sh_r == 8'hf0) ? 5 : 0;
                if (sh_r == 8'h0f) es_r[7] = 1'b0;
                ai = 0;
            end
            3: begin
                if (sh_r !== (ai == 0 ? ta_lo_r : ai == 1 ? ta_hi_r : es_r)) st = 0;
                else if (ai == 2) begin
                    es_r[7] = 1'b1;
                    // Scratchpad holds whole bytes, so a partly written one moves whole
                    for (int i = int'(ta_lo_r[4:0]); i <= int'(es_r[4:0]); i++)
                        mem[{ta_lo_r[7:5], i[4:0]}] = pad[i];
                    // Busy here, so falling edges meanwhile go unseen
                    #COPY_NS st = 4;
                end
                ai++;
            end
            5: begin
                // Target address reloads; status byte keeps its value
                if (ai == 0) ta_lo_r = sh_r;
                else begin
                    ta_hi_r = sh_r;
                    st      = 6;
                end
                ai++;
            end
            default: st = st;
        endcase
    endtask
    always @(negedge line) begin
        if (st == 4) begin
            pull_low = 1'b1;
            #15500 pull_low = 1'b0;
            #1 if (!line) rst_seq();
        end else if (st == 6) begin
            // Past the last location the line is left alone, which reads as ones
            b = ({ta_hi_r, ta_lo_r} < 16'(MEM_BYTES)) ? mem[ta_lo_r][nb] : 1'b1;
            pull_low = !b;
            #15000 pull_low = 1'b0;
            nb++;
            if (nb == 8) begin
                nb = 0;
                {ta_hi_r, ta_lo_r} = {ta_hi_r, ta_lo_r} + 16'h0001;
            end
            #1 if (!line) rst_seq();
        end else begin
            #4000 b = line;
            #6000 if (!line) rst_seq();
            else if (st != 0) begin
                sh_r = {b, sh_r[7:1]};
                nb++;
                if (nb == 8) begin
                    nb = 0;
                    take_byte();
                end
            end
        end
    end
endmodule // swm_dev_model

// [tb_top.sv]
`timescale 1ns/1ns
module tb_top;
    logic        pclk, presetn, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, dq_o, dq_oe, dev_low, err;
    logic [7:0]  auth [3] = '{8'h26, 8'h00, 8'h07};
    int          mismatches, cmp_count;
    // Pull-up wins unless someone pulls down
    wire         line = !((dq_oe && !dq_o) || dev_low);
    swm_master #(.RSTL_CYC(2000), .RSTH_CYC(2000), .PRES_CYC(150), .SLOT_CYC(1600), .LOW0_CYC(600)) u_swm_master (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .dq_i(line), .dq_o(dq_o),
        .dq_oe(dq_oe));
    swm_dev_model u_swm_dev_model (.line(line), .pull_low(dev_low));
    always #5 pclk = ~pclk;
    task automatic complete_run();
        if (mismatches == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            chk({31'h0, pready}, 32'h1);
            complete_run();
        end
        // Idle cycle keeps each driver to one assignment per step
        @(posedge pclk);
    endtask
    task automatic run_op(input logic [1:0] o, input logic [7:0] b);
        int n;
        n = 0;
        apb(1'b1, 12'h000, {16'h0000, b, 6'h00, o});
        do begin
            repeat (40) @(posedge pclk);
            apb(1'b0, 12'h004, 32'h0);
            n++;
        end while (rd[0] !== 1'b0 && n < 1000);
        if (rd[0] !== 1'b0) begin
            chk({31'h0, rd[0]}, 32'h0);
            complete_run();
        end
    endtask
    initial begin
        pclk       = 1'b0;
        presetn    = 1'b0;
        psel       = 1'b0;
        penable    = 1'b0;
        pwrite     = 1'b0;
        paddr      = 12'h000;
        pwdata     = 32'h0;
        mismatches = 0;
        cmp_count  = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 12'h008, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        run_op(2'h1, 8'hff);
        chk({31'h0, rd[2]}, 32'h1);
        run_op(2'h0, 8'h00);
        chk({25'h0, rd[6:0]}, 32'h22);
        apb(1'b1, 12'h004, 32'h0000ffff);
        apb(1'b0, 12'h004, 32'h0);
        chk({25'h0, rd[6:0]}, 32'h22);
        run_op(2'h1, 8'hcc);
        chk({30'h0, rd[6:5]}, 32'h2);
        apb(1'b0, 12'h000, 32'h0);
        chk({16'h0, rd[15:0]}, 32'hcc01);
        run_op(2'h1, 8'h55);
        chk({30'h0, rd[6:5]}, 32'h3);
        foreach (auth[i]) run_op(2'h1, auth[i]);
        chk({31'h0, rd[3]}, 32'h1);
        run_op(2'h3, 8'h00);
        chk({30'h0, rd[8], rd[4]}, 32'h1);
        run_op(2'h0, 8'h00);
        chk({29'h0, rd[6:5], rd[1]}, 32'h3);
        chk({31'h0, line}, 32'h1);
        complete_run();
    end
endmodule // tb_top
